/* File: dmer_err_asserts.sv */
// Checker for the error flag block: APB handshake, read-back and pulse shape.
// Assumes it is bound to dmer_error_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`include "dmer_map.vh"
module dmer_err_asserts (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] quick_event,
    input wire [7:0] quick_null_entry,
    input wire [63:0] direct_miss_event,
    input wire completion_issue,
    input wire [4:0] queue0_depth,
    input wire [4:0] queue1_depth,
    input wire error_irq_pulse
);
    reg [2:0] since_r;
    wire take = psel && penable && !pready;
    wire rd_end = psel && penable && pready && !pwrite;
    // Loose on purpose: any write or event may explain a later firing
    wire cause = (take && pwrite) || (|quick_event) || (|quick_null_entry) ||
        (|direct_miss_event) || completion_issue || (|queue0_depth) || (|queue1_depth);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Cycles since the last possible cause, saturating
    always @(posedge core_clk) begin
        if (reset || cause) since_r <= 3'h0;
        else if (since_r != 3'h7) since_r <= since_r + 3'h1;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence
    AST_PULSE_ONE: assert property (error_irq_pulse |=> !error_irq_pulse)
        else $error("error pulse wider than one clock");
    AST_PULSE_CAUSE: assert property (error_irq_pulse |-> since_r <= 3'h4)
        else $error("error pulse without a recent cause");
    AST_READY_WAIT: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready missing after one wait state");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside a transfer end");
    AST_BAD_READ_ZERO: assert property (rd_end && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    AST_QMISS_RSVD: assert property (rd_end && paddr == `DMER_ADDR_QMISS_FLAGS
        |-> prdata[31:8] == 24'h00_0000)
        else $error("quick miss reserved bits set");
    AST_CERR_RSVD: assert property (rd_end && paddr == `DMER_ADDR_CERR_FLAGS
        |-> (prdata & ~`DMER_CERR_MASK) == `DMER_ZERO32)
        else $error("controller error reserved bits set");
    AST_REEVAL_READ: assert property (rd_end && paddr == `DMER_ADDR_REEVAL
        |-> prdata[31:2] == 30'h0000_0000 && !prdata[0])
        else $error("re-evaluate read not zero");
endmodule
bind dmer_error_ctrl dmer_err_asserts dmer_err_asserts_i (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .quick_event(quick_event),
    .quick_null_entry(quick_null_entry), .direct_miss_event(direct_miss_event),
    .completion_issue(completion_issue), .queue0_depth(queue0_depth),
    .queue1_depth(queue1_depth), .error_irq_pulse(error_irq_pulse));

/* File: dmer_error_ctrl.v */
// Error flag and error interrupt logic of a DMA channel controller.
// Assumes an APB master on core_clk and event inputs synchronous to it.
// Summary of operation
// (RULE_01) Writing one to quick-miss clear bits 7-0 clears that missed flag.
// (RULE_02) No new error interrupt until all error flags clear, except re-evaluate.
// (RULE_03) Queue 0 or 1 depth at or above watermark sets its threshold flag.
// (RULE_04) More than 63 outstanding completion codes sets overflow flag bit 16.
// (RULE_05) A controller error flag setting from all-clear raises the interrupt.
// (RULE_06) Controller error flags are read-only and cleared only by clear register.
// (RULE_07) Writing one to a controller error clear bit clears that flag.
// (RULE_08) Clear bit 16 clears the completion code overflow flag.
// (RULE_09) Clear bit 1 clears queue 1 flag, peak count and exceeded field.
// (RULE_10) Clear bit 0 clears queue 0 flag, peak count and exceeded field.
// (RULE_11) Interrupt fires again only on transition from no flags to some.
// (RULE_12) Re-evaluate bit 0 written one re-fires interrupt if flags remain.
// (RULE_13) Software always writes zero to re-evaluate bit 1.
// (RULE_14) Second event before service, or null entry, sets quick-miss flag.
// (RULE_15) Re-evaluate pulses if direct, quick or controller errors remain.
// (RULE_16) Each interrupt firing is a one-clock pulse on the error output.
// (RULE_17) Reserved bits read zero and ignore writes; re-evaluate bit 1 is stored and reads back.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "dmer_map.vh"

module dmer_error_ctrl (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] quick_event,
    input wire [7:0] quick_pending,
    input wire [7:0] quick_null_entry,
    input wire [63:0] direct_miss_event,
    input wire completion_issue,
    input wire completion_return,
    input wire [4:0] queue0_depth,
    input wire [4:0] queue1_depth,
    output reg error_irq_pulse,
    output reg irq
);

    // Byte-address decode for the write strobes; the read mux decodes paddr itself
    function sel;
        input [11:0] a;
        input [11:0] target;
        begin
            sel = (a == target);
        end
    endfunction

    wire wr_access;
    wire rd_access;
    wire wr_qclr, wr_cclr, wr_reeval, wr_wmark, wr_dclr_lo, wr_dclr_hi, wr_istat, wr_imask;
    wire mapped;
    reg [7:0] quick_miss_flags_r;
    reg [2:0] cerr_r;
    reg [63:0] direct_miss_r;
    reg [`DMER_CODE_W-1:0] code_count_r;
    reg [`DMER_CNT_W-1:0] wmark_r;
    reg reeval_rsvd_r;
    reg any_err_d_r;
    reg [`DMER_IRQ_W-1:0] irq_status_r;
    reg [`DMER_IRQ_W-1:0] irq_mask_r;
    reg [31:0] rdata_nxt;
    wire [7:0] quick_set;
    wire q0_thr, q1_thr;
    wire [4:0] q0_peak, q1_peak;
    wire q0_exc, q1_exc;
    wire code_over;
    wire any_err;
    wire fire;
    wire [`DMER_IRQ_W-1:0] irq_events;
    wire q0_clr, q1_clr;

    // Access phase with one wait state: a write is taken in the first penable cycle, a read in the setup cycle
    assign wr_access = psel && penable && pwrite && !pready;
    assign rd_access = psel && !penable && !pwrite;
    assign wr_qclr = wr_access && sel(paddr, `DMER_ADDR_QMISS_CLEAR);
    assign wr_cclr = wr_access && sel(paddr, `DMER_ADDR_CERR_CLEAR);
    assign wr_reeval = wr_access && sel(paddr, `DMER_ADDR_REEVAL);
    assign wr_wmark = wr_access && sel(paddr, `DMER_ADDR_WMARK);
    assign wr_dclr_lo = wr_access && sel(paddr, `DMER_ADDR_DMISS_CLR_LO);
    assign wr_dclr_hi = wr_access && sel(paddr, `DMER_ADDR_DMISS_CLR_HI);
    assign wr_istat = wr_access && sel(paddr, `DMER_ADDR_IRQ_STATUS);
    assign wr_imask = wr_access && sel(paddr, `DMER_ADDR_IRQ_MASK);
    assign mapped = (paddr <= `DMER_ADDR_IRQ_MASK) && (paddr[1:0] == 2'b00);

    // Missed quick-channel event: new event while one pending, or null entry
    assign quick_set = (quick_event & quick_pending) | quick_null_entry; // RULE_14

    // Queue clear strobes also reset the status fields in each monitor
    assign q0_clr = wr_cclr && pwdata[`DMER_BIT_Q0_THR]; // RULE_10
    assign q1_clr = wr_cclr && pwdata[`DMER_BIT_Q1_THR]; // RULE_09

    dmer_queue_mon u_q0 (
        .core_clk(core_clk),
        .reset(reset),
        .queue_depth(queue0_depth),
        .queue_watermark_threshold(wmark_r),
        .clear_pulse(q0_clr),
        .queue_peak_count(q0_peak),
        .queue_threshold_exceeded(q0_exc),
        .thr_set_pulse(q0_thr)
    );

    dmer_queue_mon u_q1 (
        .core_clk(core_clk),
        .reset(reset),
        .queue_depth(queue1_depth),
        .queue_watermark_threshold(wmark_r),
        .clear_pulse(q1_clr),
        .queue_peak_count(q1_peak),
        .queue_threshold_exceeded(q1_exc),
        .thr_set_pulse(q1_thr)
    );

    // Outstanding completion codes beyond the limit flag an overflow
    assign code_over = (code_count_r > `DMER_CODE_MAX); // RULE_04

    // Counter saturates so a long burst cannot wrap back under the limit
    always @(posedge core_clk) begin
        if (reset) begin
            code_count_r <= {`DMER_CODE_W{1'b0}};
        end else if (completion_issue && !completion_return) begin
            if (code_count_r != {`DMER_CODE_W{1'b1}}) begin
                code_count_r <= code_count_r + 1'b1;
            end
        end else if (completion_return && !completion_issue) begin
            if (code_count_r != {`DMER_CODE_W{1'b0}}) begin
                code_count_r <= code_count_r - 1'b1;
            end
        end
    end

    // Quick-channel missed flags; a set arriving with a clear wins
    always @(posedge core_clk) begin
        if (reset) begin
            quick_miss_flags_r <= 8'h00;
        end else begin
            quick_miss_flags_r <= (quick_miss_flags_r
                & ~(wr_qclr ? pwdata[`DMER_QMISS_W-1:0] : 8'h00)) // RULE_01
                | quick_set; // RULE_14
        end
    end

    // Direct-channel missed flags, cleared through two write-one registers
    always @(posedge core_clk) begin
        if (reset) begin
            direct_miss_r <= {2{`DMER_ZERO32}};
        end else begin
            direct_miss_r <= (direct_miss_r
                & ~{(wr_dclr_hi ? pwdata : `DMER_ZERO32), (wr_dclr_lo ? pwdata : `DMER_ZERO32)})
                | direct_miss_event;
        end
    end

    // Controller error flags: bit0/1 queue thresholds, bit2 code overflow
    always @(posedge core_clk) begin
        if (reset) begin
            cerr_r <= 3'b000;
        end else begin
            cerr_r[0] <= (cerr_r[0] && !q0_clr) || q0_thr; // RULE_03 RULE_06 RULE_07
            cerr_r[1] <= (cerr_r[1] && !q1_clr) || q1_thr; // RULE_03 RULE_06 RULE_07
            cerr_r[2] <= (cerr_r[2] && !(wr_cclr && pwdata[`DMER_BIT_CODE_OVF]))
                || code_over; // RULE_04 RULE_08
        end
    end

    // Watermark and the reserved evaluate bit that software must keep zero
    always @(posedge core_clk) begin
        if (reset) begin
            wmark_r <= `DMER_WMARK_RST;
            reeval_rsvd_r <= 1'b0;
        end else begin
            if (wr_wmark) begin
                wmark_r <= pwdata[`DMER_CNT_W-1:0];
            end
            if (wr_reeval) begin
                reeval_rsvd_r <= pwdata[`DMER_BIT_REEVAL_RSVD]; // RULE_13
            end
        end
    end

    // Any error across direct, quick and controller registers
    assign any_err = (|direct_miss_r) || (|quick_miss_flags_r) || (|cerr_r);

    // Fire on the all-clear to some-set edge, or on re-evaluate with errors
    assign fire = (any_err && !any_err_d_r) // RULE_02 RULE_05 RULE_11
        || (wr_reeval && pwdata[`DMER_BIT_REEVAL] && any_err); // RULE_12 RULE_15

    always @(posedge core_clk) begin
        if (reset) begin
            any_err_d_r <= 1'b0;
            error_irq_pulse <= 1'b0;
        end else begin
            any_err_d_r <= any_err;
            error_irq_pulse <= fire; // RULE_16
        end
    end

    // Sticky status for the level interrupt; set beats write-one clear
    assign irq_events = {cerr_r[0] | cerr_r[1], cerr_r[2], fire};

    always @(posedge core_clk) begin
        if (reset) begin
            irq_status_r <= {`DMER_IRQ_W{1'b0}};
            irq_mask_r <= {`DMER_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_status_r <= (irq_status_r
                & ~(wr_istat ? pwdata[`DMER_IRQ_W-1:0] : {`DMER_IRQ_W{1'b0}})) | irq_events;
            if (wr_imask) begin
                irq_mask_r <= pwdata[`DMER_IRQ_W-1:0];
            end
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // Read mux; write-only fields and reserved fields other than re-evaluate bit 1 read as zero
    always @* begin
        rdata_nxt = `DMER_ZERO32;
        case (paddr)
            `DMER_ADDR_QMISS_FLAGS: rdata_nxt[`DMER_QMISS_W-1:0] = quick_miss_flags_r; // RULE_17
            `DMER_ADDR_CERR_FLAGS: begin
                rdata_nxt[`DMER_BIT_Q0_THR] = cerr_r[0];
                rdata_nxt[`DMER_BIT_Q1_THR] = cerr_r[1];
                rdata_nxt[`DMER_BIT_CODE_OVF] = cerr_r[2]; // RULE_17
            end
            `DMER_ADDR_REEVAL: rdata_nxt[`DMER_BIT_REEVAL_RSVD] = reeval_rsvd_r;
            `DMER_ADDR_WMARK: rdata_nxt[`DMER_CNT_W-1:0] = wmark_r;
            `DMER_ADDR_Q0_STATUS: begin
                rdata_nxt[`DMER_CNT_W-1:0] = q0_peak;
                rdata_nxt[`DMER_QST_EXC_BIT] = q0_exc;
            end
            `DMER_ADDR_Q1_STATUS: begin
                rdata_nxt[`DMER_CNT_W-1:0] = q1_peak;
                rdata_nxt[`DMER_QST_EXC_BIT] = q1_exc;
            end
            `DMER_ADDR_DMISS_LO: rdata_nxt = direct_miss_r[31:0];
            `DMER_ADDR_DMISS_HI: rdata_nxt = direct_miss_r[63:32];
            `DMER_ADDR_IRQ_STATUS: rdata_nxt[`DMER_IRQ_W-1:0] = irq_status_r;
            `DMER_ADDR_IRQ_MASK: rdata_nxt[`DMER_IRQ_W-1:0] = irq_mask_r;
            default: rdata_nxt = `DMER_ZERO32;
        endcase
    end

    // APB answer: ready one cycle into the access phase, error if unmapped
    always @(posedge core_clk) begin
        if (reset) begin
            prdata <= `DMER_ZERO32;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (rd_access) begin
                prdata <= rdata_nxt;
            end
        end
    end

endmodule

/* File: dmer_error_ctrl_tb.sv */
// Self-checking bench for the error flag block, driven over APB.
// Assumes dmer_evt_src stands in for the channel logic around it.
`timescale 1ns/10ps
`include "dmer_map.vh"
module dmer_error_ctrl_tb;
    localparam [31:0] ONE = 32'h0000_0001;
    localparam [31:0] NIL = 32'h0000_0000;
    reg core_clk, reset, psel, penable, pwrite, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, q, p0, fails, checks;
    reg [31:0] pulses = 32'h0000_0000;
    reg [31:0] cyc = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready, pslverr, error_irq_pulse, irq, completion_issue, completion_return;
    wire [7:0] quick_event, quick_pending, quick_null_entry;
    wire [63:0] direct_miss_event;
    wire [4:0] queue0_depth, queue1_depth;
    dmer_error_ctrl dmer_error_ctrl_i (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .quick_event(quick_event),
        .quick_pending(quick_pending), .quick_null_entry(quick_null_entry),
        .direct_miss_event(direct_miss_event), .completion_issue(completion_issue),
        .completion_return(completion_return), .queue0_depth(queue0_depth),
        .queue1_depth(queue1_depth), .error_irq_pulse(error_irq_pulse), .irq(irq));
    dmer_evt_src dmer_evt_src_i (.core_clk(core_clk), .quick_event(quick_event),
        .quick_pending(quick_pending), .quick_null_entry(quick_null_entry),
        .direct_miss_event(direct_miss_event), .completion_issue(completion_issue),
        .completion_return(completion_return), .queue0_depth(queue0_depth),
        .queue1_depth(queue1_depth));
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Firing counter and hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + ONE;
        if (error_irq_pulse === 1'h1) pulses <= pulses + ONE;
        if (cyc == 32'h0000_4E20) begin
            fails = fails + ONE;
            test_done;
        end
    end
    task test_done;
        begin
            $display("checks=%0d fails=%0d", checks, fails);
            if (fails == NIL && checks != NIL) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + ONE;
            if (got !== exp) begin
                fails = fails + ONE;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; waits for pready with no assumed latency
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'h1;
            @(posedge core_clk);
            while (pready !== 1'h1) @(posedge core_clk);
            q = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rdc(input [11:0] a, input [31:0] exp);
        begin
            apb(1'h0, a, NIL);
            chk(q, exp);
        end
    endtask
    task t_rst;
        begin
            rdc(`DMER_ADDR_CERR_FLAGS, NIL);
            rdc(`DMER_ADDR_QMISS_FLAGS, NIL);
            rdc(`DMER_ADDR_REEVAL, NIL);
            rdc(`DMER_ADDR_WMARK, 32'h0000_0010);
            chk(irq, NIL);
        end
    endtask
    // Misses on all quick channels fire once; clears and re-evaluate
    task t_quick;
        integer c;
        begin
            p0 = pulses;
            for (c = 0; c < 8; c = c + 1) dmer_evt_src_i.qev(c, c == 3);
            repeat (4) @(posedge core_clk);
            chk(pulses - p0, ONE);
            rdc(`DMER_ADDR_QMISS_FLAGS, 32'h0000_00FF);
            p0 = pulses;
            wr(`DMER_ADDR_REEVAL, NIL);
            wr(`DMER_ADDR_REEVAL, ONE);
            repeat (3) @(posedge core_clk);
            chk(pulses - p0, ONE);
            wr(`DMER_ADDR_QMISS_CLEAR, 32'hFFFF_FF00);
            rdc(`DMER_ADDR_QMISS_FLAGS, 32'h0000_00FF);
            wr(`DMER_ADDR_QMISS_CLEAR, 32'h0000_0081);
            rdc(`DMER_ADDR_QMISS_FLAGS, 32'h0000_007E);
            wr(`DMER_ADDR_QMISS_CLEAR, 32'h0000_00FF);
            p0 = pulses;
            wr(`DMER_ADDR_REEVAL, ONE);
            repeat (3) @(posedge core_clk);
            chk(pulses - p0, NIL);
            dmer_evt_src_i.qev(6, 1'h0);
            repeat (3) @(posedge core_clk);
            chk(pulses - p0, ONE);
            wr(`DMER_ADDR_QMISS_CLEAR, 32'h0000_00FF);
        end
    endtask
    // Outstanding completion codes: 63 is fine, 64 overflows
    task t_ovf;
        begin
            p0 = pulses;
            dmer_evt_src_i.cmp(1'h1, 63);
            repeat (3) @(posedge core_clk);
            rdc(`DMER_ADDR_CERR_FLAGS, NIL);
            dmer_evt_src_i.cmp(1'h1, 1);
            repeat (3) @(posedge core_clk);
            rdc(`DMER_ADDR_CERR_FLAGS, 32'h0001_0000);
            chk(pulses - p0, ONE);
            wr(`DMER_ADDR_CERR_FLAGS, 32'hFFFF_FFFF);
            rdc(`DMER_ADDR_CERR_FLAGS, 32'h0001_0000);
            wr(`DMER_ADDR_CERR_CLEAR, 32'hFFFE_FFFF);
            rdc(`DMER_ADDR_CERR_FLAGS, 32'h0001_0000);
            dmer_evt_src_i.cmp(1'h0, 1);
            wr(`DMER_ADDR_CERR_CLEAR, 32'h0001_0000);
            rdc(`DMER_ADDR_CERR_FLAGS, NIL);
        end
    endtask
    // Watermark crossing and clear for each queue
    task t_queue;
        integer k;
        begin
            wr(`DMER_ADDR_WMARK, 32'h0000_0004);
            for (k = 0; k < 2; k = k + 1) begin
                dmer_evt_src_i.dep(k, 5'h03);
                repeat (4) @(posedge core_clk);
                rdc(`DMER_ADDR_CERR_FLAGS, NIL);
                dmer_evt_src_i.dep(k, 5'h04);
                repeat (4) @(posedge core_clk);
                rdc(`DMER_ADDR_CERR_FLAGS, ONE << k);
                rdc(`DMER_ADDR_Q0_STATUS + 4 * k, 32'h0000_0104);
                dmer_evt_src_i.dep(k, 5'h00);
                wr(`DMER_ADDR_CERR_CLEAR, ONE << k);
                rdc(`DMER_ADDR_CERR_FLAGS, NIL);
                rdc(`DMER_ADDR_Q0_STATUS + 4 * k, NIL);
            end
        end
    endtask
    // Interrupt status, mask, clear, and a refused address
    task t_irq;
        begin
            rdc(`DMER_ADDR_IRQ_STATUS, 32'h0000_0007);
            wr(`DMER_ADDR_IRQ_STATUS, 32'h0000_0007);
            rdc(`DMER_ADDR_IRQ_STATUS, NIL);
            wr(`DMER_ADDR_IRQ_MASK, ONE);
            dmer_evt_src_i.dev(40);
            repeat (4) @(posedge core_clk);
            rdc(`DMER_ADDR_DMISS_HI, 32'h0000_0100);
            chk(irq, ONE);
            wr(`DMER_ADDR_IRQ_MASK, NIL);
            repeat (2) @(posedge core_clk);
            chk(irq, NIL);
            wr(`DMER_ADDR_IRQ_MASK, ONE);
            wr(`DMER_ADDR_IRQ_STATUS, ONE);
            repeat (2) @(posedge core_clk);
            chk(irq, NIL);
            wr(`DMER_ADDR_DMISS_CLR_HI, 32'h0000_0100);
            rdc(`DMER_ADDR_DMISS_HI, NIL);
            apb(1'h0, 12'h040, NIL);
            chk(err, ONE);
            chk(q, NIL);
        end
    endtask
    initial begin
        fails = NIL;
        checks = NIL;
        reset = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = NIL;
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        t_rst;
        t_quick;
        t_ovf;
        t_queue;
        t_irq;
        test_done;
    end
endmodule

/* File: dmer_evt_src.sv */
// Model of the channel logic that feeds events into the error flag block.
// Assumes one caller thread; every task starts one edge late so no
// signal is assigned twice in a time step.
`timescale 1ns/10ps
module dmer_evt_src (
    input wire core_clk,
    output reg [7:0] quick_event,
    output reg [7:0] quick_pending,
    output reg [7:0] quick_null_entry,
    output reg [63:0] direct_miss_event,
    output reg completion_issue,
    output reg completion_return,
    output reg [4:0] queue0_depth,
    output reg [4:0] queue1_depth
);
    // Idle levels: no events, empty queues
    initial begin
        quick_event = 8'h00;
        quick_pending = 8'h00;
        quick_null_entry = 8'h00;
        direct_miss_event = 64'h0;
        completion_issue = 1'h0;
        completion_return = 1'h0;
        queue0_depth = 5'h00;
        queue1_depth = 5'h00;
    end
    // Quick event on a busy channel, or one meeting a null entry
    task qev(input integer ch, input nul);
        begin
            @(posedge core_clk);
            quick_event[ch] <= 1'h1;
            quick_pending[ch] <= !nul;
            quick_null_entry[ch] <= nul;
            @(posedge core_clk);
            quick_event <= 8'h00;
            quick_pending <= 8'h00;
            quick_null_entry <= 8'h00;
        end
    endtask
    // Direct channel miss pulse
    task dev(input integer idx);
        begin
            @(posedge core_clk);
            direct_miss_event[idx] <= 1'h1;
            @(posedge core_clk);
            direct_miss_event <= 64'h0;
        end
    endtask
    // Separate one-clock issue or return pulses
    task cmp(input iss, input integer n);
        repeat (n) begin
            @(posedge core_clk);
            completion_issue <= iss;
            completion_return <= !iss;
            @(posedge core_clk);
            completion_issue <= 1'h0;
            completion_return <= 1'h0;
        end
    endtask
    task dep(input integer qn, input [4:0] v);
        begin
            @(posedge core_clk);
            if (qn == 0) queue0_depth <= v;
            else queue1_depth <= v;
        end
    endtask
endmodule

/* File: dmer_map.vh */
// Register map, field positions and constants of the DMA error flag block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef DMER_MAP_VH
`define DMER_MAP_VH

// Register byte addresses (APB, word aligned)
`define DMER_ADDR_QMISS_FLAGS 12'h000
`define DMER_ADDR_QMISS_CLEAR 12'h004
`define DMER_ADDR_CERR_FLAGS 12'h008
`define DMER_ADDR_CERR_CLEAR 12'h00C
`define DMER_ADDR_REEVAL 12'h010
`define DMER_ADDR_WMARK 12'h014
`define DMER_ADDR_Q0_STATUS 12'h018
`define DMER_ADDR_Q1_STATUS 12'h01C
`define DMER_ADDR_DMISS_LO 12'h020
`define DMER_ADDR_DMISS_HI 12'h024
`define DMER_ADDR_DMISS_CLR_LO 12'h028
`define DMER_ADDR_DMISS_CLR_HI 12'h02C
`define DMER_ADDR_IRQ_STATUS 12'h030
`define DMER_ADDR_IRQ_MASK 12'h034

// Field positions
`define DMER_QMISS_W 8
`define DMER_BIT_Q0_THR 0
`define DMER_BIT_Q1_THR 1
`define DMER_BIT_CODE_OVF 16
`define DMER_BIT_REEVAL 0
`define DMER_BIT_REEVAL_RSVD 1
`define DMER_CERR_MASK 32'h0001_0003
`define DMER_QMISS_MASK 32'h0000_00FF

// Queue status field layout: peak count [4:0], exceeded flag bit 8
`define DMER_CNT_W 5
`define DMER_QST_EXC_BIT 8

// Outstanding completion code counter width and limit
`define DMER_CODE_W 7
`define DMER_CODE_MAX 7'h3F

// Interrupt status bit positions
`define DMER_IRQ_W 3
`define DMER_IRQ_ERR 0
`define DMER_IRQ_CODE 1
`define DMER_IRQ_THR 2

// Reset values
`define DMER_ZERO32 32'h0000_0000
`define DMER_WMARK_RST 5'h10

`endif

/* File: dmer_queue_mon.v */
// Per-queue watermark monitor: peak count, exceeded flag and threshold event.
// Assumes the queue depth input is synchronous to core_clk.
`timescale 1ns/10ps
`include "dmer_map.vh"

module dmer_queue_mon (
    input wire core_clk,
    input wire reset,
    input wire [`DMER_CNT_W-1:0] queue_depth,
    input wire [`DMER_CNT_W-1:0] queue_watermark_threshold,
    input wire clear_pulse,
    output reg [`DMER_CNT_W-1:0] queue_peak_count,
    output reg queue_threshold_exceeded,
    output reg thr_set_pulse
);

    wire at_or_over;

    // Reaching the watermark counts as an error, not only passing it
    assign at_or_over = (queue_depth >= queue_watermark_threshold); // RULE_03

    // Status fields; a clear from software drops the peak to the current depth and the flag, a same-cycle hit re-sets
    always @(posedge core_clk) begin
        if (reset) begin
            queue_peak_count <= {`DMER_CNT_W{1'b0}};
            queue_threshold_exceeded <= 1'b0;
            thr_set_pulse <= 1'b0;
        end else begin
            thr_set_pulse <= at_or_over; // RULE_03
            if (clear_pulse) begin
                queue_peak_count <= queue_depth; // RULE_09 RULE_10
                queue_threshold_exceeded <= at_or_over;
            end else begin
                if (queue_depth > queue_peak_count) begin
                    queue_peak_count <= queue_depth;
                end
                if (at_or_over) begin
                    queue_threshold_exceeded <= 1'b1;
                end
            end
        end
    end

endmodule
